/* File: failsafe_reset_output_ctrl.sv */
/*
 * Fail-safe power-good and reset output control with pulse timing,
 * stuck-high and stuck-low detection, release timing and fault counting.
 * Assumes monitor faults and requests are synchronous to core_clk; pin
 * levels arrive asynchronously. Configuration is latched when init_done rises.
 */
// Function
// - Power-good asserted always forces reset asserted too.
// - Reset may assert alone without pulling power-good low.
// - Power-good low while any assigned monitor shows over or undervoltage.
// - Core, IO and aux monitors each selectable as power-good source.
// - Standby and power down hold both outputs low.
// - Reset-causing faults follow configuration latched in the init phase.
// - Reset line low longer than eight seconds enters deep fail-safe, except in standby and power down.
// - Pulse length select picks long or short reset pulse.
// - Stuck-high reported after mismatch persists for the filter time.
// - Reset released 8 ms after wake-up or power-on reset.
// - Link bit set makes every reset fault also assert power-good.
// - Faults not asserting reset leave fault counter unchanged, except other_fault and stuck-high, which count.
// - Fault counter starts at one after reset or leaving standby.
// - Two-bit select sets counter maximum to 2, 6, 8 or 12.
`timescale 1ns/100ps
module failsafe_reset_output_ctrl
	import fsro_pkg::*;
#(
	parameter longint unsigned STUCK_LOW_CYCLES = fsro_pkg::STUCK_LOW_CYC,
	parameter int unsigned     RELEASE_CYCLES   = fsro_pkg::RELEASE_CYC
) (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// Mode and configuration
	input  wire logic                 low_power_mode,
	input  wire logic                 init_done,
	input  wire fsro_pkg::fs_cfg_t    cfg_in,
	// Fault sources
	input  wire fsro_pkg::mon_fault_t mon_fault,
	input  wire logic                 pulse_req,
	input  wire logic                 other_fault,
	// Power-good pin
	output logic                      power_good_n_oe,
	output logic                      power_good_n_o,
	input  wire logic                 power_good_n_i,
	// Reset pin
	output logic                      reset_out_n_oe,
	output logic                      reset_out_n_o,
	input  wire logic                 reset_out_n_i,
	// Status
	output logic                      stuck_high_flag,
	output logic                      deep_failsafe_state,
	output logic [3:0]                fault_error_count,
	output logic                      fault_diag_flag
);
	import fsro_pkg::*;

	initial begin
		if (STUCK_LOW_CYCLES < 2 || STUCK_LOW_CYCLES > 64'hFFFF_FFFF || RELEASE_CYCLES < 1)
			$error("failsafe_reset_output_ctrl: unsupported timer parameters");
	end

	typedef enum logic [1:0] {ST_STARTUP, ST_RUN, ST_PULSE, ST_HOLD} rst_state_t;

	fs_cfg_t    cfg_r, cfg_nxt;
	logic       init_seen_r, init_seen_nxt;
	rst_state_t st_r, st_nxt;
	logic [31:0] tmr_r, tmr_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic       deep_r, deep_nxt;
	logic       stuck_r, stuck_nxt;
	logic       diag_r, diag_nxt;
	logic       pg_low_r, pg_low_nxt;
	logic       rst_low_r, rst_low_nxt;
	logic       rel_hi_r, rel_hi_nxt;
	logic       ext_low_prev_r;

	logic       rst_pin_lvl;
	logic       pg_pin_lvl;
	logic       pg_fault;
	logic       rst_fault;
	logic       diag_fault;
	logic       rst_fault_prev_r;
	logic       ext_reset;
	logic       stuck_low_done;
	logic       stuck_hi_done;
	logic [3:0] cnt_max;
	logic [31:0] pulse_len;

	// Pin feedback synchronisers
	fsro_sync #(.RST_VAL(1'b0)) u_sync_rst (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.pin_in    (reset_out_n_i),
		.level_out (rst_pin_lvl)
	);

	fsro_sync #(.RST_VAL(1'b0)) u_sync_pg (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.pin_in    (power_good_n_i),
		.level_out (pg_pin_lvl)
	);

	// Reset line observed low for eight seconds
	fsro_timer #(.W(32)) u_t8s (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.run      (!rst_pin_lvl && !low_power_mode && !deep_r),
		.limit    (STUCK_LOW_CYCLES[31:0]),
		.done     (stuck_low_done)
	);

	// Commanded low but sensed high
	fsro_timer #(.W(32)) u_tsc (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.run      (rst_low_r && rst_pin_lvl),
		.limit    (STUCK_HI_CYC),
		.done     (stuck_hi_done)
	);

	// Fault decode from latched configuration
	always_comb begin
		pg_fault   = |((mon_fault.ov | mon_fault.uv) & cfg_r.pg_assign);
		rst_fault  = |((mon_fault.ov & cfg_r.ov_rst_en) |
			(mon_fault.uv & cfg_r.uv_rst_en));
		diag_fault = |((mon_fault.ov & ~cfg_r.ov_rst_en) |
			(mon_fault.uv & ~cfg_r.uv_rst_en));
		unique case (cfg_r.fault_count_max_sel)
			2'h0: cnt_max = CNT_MAX_00;
			2'h1: cnt_max = CNT_MAX_01;
			2'h2: cnt_max = CNT_MAX_10;
			2'h3: cnt_max = CNT_MAX_11;
		endcase
		pulse_len  = cfg_r.reset_pulse_length_sel ? LONG_PULSE_CYC : SHORT_PULSE_CYC;
		// Only a line seen high since release counts, so synchroniser lag is no false reset
		ext_reset  = (st_r == ST_RUN) && !rst_low_r && rel_hi_r && !rst_pin_lvl;
	end

	// Configuration capture, reset sequencing and fault counting
	always_comb begin
		cfg_nxt       = cfg_r;
		init_seen_nxt = init_seen_r;
		st_nxt        = st_r;
		tmr_nxt       = tmr_r;
		cnt_nxt       = cnt_r;
		deep_nxt      = deep_r;
		stuck_nxt     = stuck_r || stuck_hi_done;
		diag_nxt      = diag_r || diag_fault;
		rel_hi_nxt    = !rst_low_r && (rel_hi_r || (st_r == ST_RUN && rst_pin_lvl));
		if (init_done && !init_seen_r) begin
			cfg_nxt       = cfg_in;
			init_seen_nxt = 1'b1;
		end
		if (stuck_low_done)
			deep_nxt = 1'b1;
		if (low_power_mode) begin
			st_nxt  = ST_STARTUP;
			tmr_nxt = '0;
			cnt_nxt = CNT_INIT;
		end else begin
			unique case (st_r)
				ST_STARTUP: begin
					if (tmr_r + 32'h1 >= RELEASE_CYCLES) begin
						st_nxt  = ST_RUN;
						tmr_nxt = '0;
					end else
						tmr_nxt = tmr_r + 32'h1;
				end
				ST_RUN: begin
					if ((rst_fault && !rst_fault_prev_r) || pulse_req || ext_reset) begin
						st_nxt  = ST_PULSE;
						tmr_nxt = '0;
					end
				end
				ST_PULSE: begin
					if (tmr_r + 32'h1 >= pulse_len) begin
						st_nxt  = ST_HOLD;
						tmr_nxt = '0;
					end else
						tmr_nxt = tmr_r + 32'h1;
				end
				ST_HOLD: begin
					if (!rst_fault && !pg_fault)
						st_nxt = ST_RUN;
				end
			endcase
			// Count reset-causing events, stuck-high and other_fault, never requests or masked faults
			if (((rst_fault && !rst_fault_prev_r) || (ext_reset && !ext_low_prev_r) ||
				stuck_hi_done && !stuck_r || other_fault) && st_r != ST_STARTUP) begin
				if (cnt_r >= cnt_max)
					deep_nxt = 1'b1;
				else
					cnt_nxt = cnt_r + 4'h1;
			end
		end
		// Output levels
		pg_low_nxt  = low_power_mode || deep_nxt || pg_fault ||
			(cfg_r.pg_reset_link_cfg && (rst_fault || st_nxt == ST_PULSE));
		rst_low_nxt = pg_low_nxt || st_nxt != ST_RUN || rst_fault;
	end

	// Register all state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r            <= '0;
			cfg_r.fault_count_max_sel <= CNT_SEL_RST;
			cfg_r.ov_rst_en  <= '1;
			init_seen_r      <= 1'b0;
			st_r             <= ST_STARTUP;
			tmr_r            <= '0;
			cnt_r            <= CNT_INIT;
			deep_r           <= 1'b0;
			stuck_r          <= 1'b0;
			diag_r           <= 1'b0;
			pg_low_r         <= 1'b1;
			rst_low_r        <= 1'b1;
			rel_hi_r         <= 1'b0;
			rst_fault_prev_r <= 1'b0;
			ext_low_prev_r   <= 1'b0;
		end else begin
			cfg_r            <= cfg_nxt;
			init_seen_r      <= init_seen_nxt;
			st_r             <= st_nxt;
			tmr_r            <= tmr_nxt;
			cnt_r            <= cnt_nxt;
			deep_r           <= deep_nxt;
			stuck_r          <= stuck_nxt;
			diag_r           <= diag_nxt;
			pg_low_r         <= pg_low_nxt;
			rst_low_r        <= rst_low_nxt;
			rel_hi_r         <= rel_hi_nxt;
			rst_fault_prev_r <= rst_fault;
			ext_low_prev_r   <= ext_reset;
		end
	end

	// Open-drain pins: enable pulls low, output data is constant low
	assign power_good_n_oe     = pg_low_r;
	assign power_good_n_o      = 1'b0;
	assign reset_out_n_oe      = rst_low_r;
	assign reset_out_n_o       = 1'b0;
	assign stuck_high_flag     = stuck_r;
	assign deep_failsafe_state = deep_r;
	assign fault_error_count   = cnt_r;
	assign fault_diag_flag     = diag_r;
endmodule : failsafe_reset_output_ctrl

/* File: fsro_pkg.sv */
/*
 * Shared constants and carrier types for the fail-safe reset output controller.
 * Assumes a 100 MHz core clock; all times are converted to cycle counts here.
 */
package fsro_pkg;

	// Clock rate
	localparam int unsigned CLK_HZ = 100_000_000;

	// Times as printed, in their own units
	localparam int unsigned LONG_PULSE_MIN_US  = 9000;
	localparam int unsigned SHORT_PULSE_MIN_US = 900;
	localparam int unsigned STUCK_HI_MIN_US    = 500;
	localparam int unsigned RELEASE_MS         = 8;
	localparam int unsigned STUCK_LOW_S        = 8;

	// Cycle counts derived from the times
	localparam int unsigned LONG_PULSE_CYC  = LONG_PULSE_MIN_US * (CLK_HZ / 1_000_000);
	localparam int unsigned SHORT_PULSE_CYC = SHORT_PULSE_MIN_US * (CLK_HZ / 1_000_000);
	localparam int unsigned STUCK_HI_CYC    = STUCK_HI_MIN_US * (CLK_HZ / 1_000_000);
	localparam int unsigned RELEASE_CYC     = RELEASE_MS * (CLK_HZ / 1_000);
	localparam longint unsigned STUCK_LOW_CYC = longint'(STUCK_LOW_S) * longint'(CLK_HZ);

	// Fault counter
	localparam int unsigned CNT_W       = 4;
	localparam logic [3:0]  CNT_INIT    = 4'h1;
	localparam logic [3:0]  CNT_MAX_00  = 4'h2;
	localparam logic [3:0]  CNT_MAX_01  = 4'h6;
	localparam logic [3:0]  CNT_MAX_10  = 4'h8;
	localparam logic [3:0]  CNT_MAX_11  = 4'hC;
	localparam logic [1:0]  CNT_SEL_RST = 2'h1;

	// Monitor indices
	localparam int unsigned MON_CORE = 0;
	localparam int unsigned MON_IO   = 1;
	localparam int unsigned MON_AUX  = 2;
	localparam int unsigned MON_N    = 3;

	// Fault report from the three voltage monitors
	typedef struct packed {
		logic [MON_N-1:0] ov;
		logic [MON_N-1:0] uv;
	} mon_fault_t;

	// Configuration captured during the initialization phase
	typedef struct packed {
		logic [MON_N-1:0] pg_assign;
		logic [MON_N-1:0] ov_rst_en;
		logic [MON_N-1:0] uv_rst_en;
		logic             pg_reset_link_cfg;
		logic [1:0]       fault_count_max_sel;
		logic             reset_pulse_length_sel;
	} fs_cfg_t;

	// Open-drain pin: pull-low enable plus sensed level
	typedef struct packed {
		logic pull_low;
		logic sensed;
	} od_pin_t;

endpackage : fsro_pkg

/* File: fsro_sync.sv */
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes the input is asynchronous to core_clk.
 */
`timescale 1ns/100ps
module fsro_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Data
	input  wire logic pin_in,
	output logic      level_out
);
	logic [2:0] sh_r;
	logic [2:0] sh_nxt;
	logic       lvl_r;
	logic       lvl_nxt;

	// Shift and accept a change once stages two and three agree
	always_comb begin
		sh_nxt  = {sh_r[1:0], pin_in};
		lvl_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : lvl_r;
	end

	// Register stages
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_r  <= {3{RST_VAL}};
			lvl_r <= RST_VAL;
		end else begin
			sh_r  <= sh_nxt;
			lvl_r <= lvl_nxt;
		end
	end

	assign level_out = lvl_r;
endmodule : fsro_sync

/* File: fsro_timer.sv */
/*
 * Up-counter that measures how long a condition has held.
 * Assumes a same-clock condition; done is high once the limit is reached.
 */
`timescale 1ns/100ps
module fsro_timer #(
	parameter int unsigned W = 32
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// Control
	input  wire logic         run,
	input  wire logic [W-1:0] limit,
	output logic              done
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// Count while run holds, saturate at limit, clear otherwise
	always_comb begin
		if (!run)
			cnt_nxt = '0;
		else if (cnt_r >= limit)
			cnt_nxt = cnt_r;
		else
			cnt_nxt = cnt_r + W'(1);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	assign done = run && (cnt_r >= limit);
endmodule : fsro_timer

/* File: fsro_mcu_model.sv */
/*
 * Far-side model: pull-ups on both open-drain lines and a microcontroller
 * that can hold reset low or a board fault that shorts reset high.
 * Assumes the block's pull-low enables; levels feed back to its inputs.
 */
`timescale 1ns/100ps
module fsro_mcu_model (
	// Pull-low enables from the block
	input  wire logic pg_oe,
	input  wire logic rst_oe,
	// Fault controls
	input  wire logic hold_low,
	input  wire logic short_high,
	// Resolved pin levels
	output logic      pg_pin,
	output logic      rst_pin
);
	// Wired resolution with pull-ups
	assign pg_pin  = !pg_oe;
	assign rst_pin = short_high | (!rst_oe & !hold_low);
endmodule : fsro_mcu_model

/* File: failsafe_reset_output_ctrl_checker.sv */
/*
 * Port-level checks of the fail-safe output controller.
 * Assumes cfg_in is held stable while init_done is high.
 */
`timescale 1ns/100ps
module failsafe_reset_output_ctrl_checker
	import fsro_pkg::*;
#(
	parameter longint unsigned STUCK_LOW_CYCLES = 200,
	parameter int unsigned     RELEASE_CYCLES   = 20
) (
	input wire logic                 core_clk,
	input wire logic                 rst_n,
	input wire logic                 low_power_mode,
	input wire logic                 init_done,
	input wire fsro_pkg::fs_cfg_t    cfg_in,
	input wire fsro_pkg::mon_fault_t mon_fault,
	input wire logic                 other_fault,
	input wire logic                 power_good_n_oe,
	input wire logic                 power_good_n_o,
	input wire logic                 reset_out_n_oe,
	input wire logic                 reset_out_n_o,
	input wire logic                 reset_out_n_i,
	input wire logic                 stuck_high_flag,
	input wire logic                 deep_failsafe_state,
	input wire logic [3:0]           fault_error_count
);
	logic [31:0] rel_cnt;
	logic [16:0] hi_cnt;
	logic [3:0]  lim;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Counter limit from the select field
	always_comb begin
		case (cfg_in.fault_count_max_sel)
			2'h0: lim = CNT_MAX_00;
			2'h1: lim = CNT_MAX_01;
			2'h2: lim = CNT_MAX_10;
			default: lim = CNT_MAX_11;
		endcase
	end
	// Time since release and length of a pin mismatch
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rel_cnt <= 32'h0;
			hi_cnt  <= 17'h0;
		end else begin
			rel_cnt <= low_power_mode ? 32'h0 : rel_cnt + 32'(rel_cnt != 32'hFFFFFFFF);
			hi_cnt  <= (reset_out_n_oe && reset_out_n_i) ? hi_cnt + 17'(hi_cnt != 17'h1FFFF) : 17'h0;
		end
	end
	pg_forces_rst_a: assert property (power_good_n_oe |-> reset_out_n_oe)
		else $error("power-good low without reset low");
	pg_fault_low_a: assert property (init_done && |(cfg_in.pg_assign & (mon_fault.uv | mon_fault.ov))
		|=> power_good_n_oe) else $error("assigned fault left power-good high");
	lowpwr_both_low_a: assert property (low_power_mode |=> power_good_n_oe && reset_out_n_oe)
		else $error("low power left an output high");
	deep_forces_low_a: assert property (deep_failsafe_state && $past(deep_failsafe_state)
		|-> power_good_n_oe && reset_out_n_oe) else $error("deep state left an output high");
	stuck_filter_a: assert property ($rose(stuck_high_flag) |-> hi_cnt >= STUCK_HI_CYC)
		else $error("stuck-high reported too early");
	release_hold_a: assert property (rel_cnt < RELEASE_CYCLES - 1 |-> reset_out_n_oe)
		else $error("reset released too early");
	link_pg_a: assert property (init_done && cfg_in.pg_reset_link_cfg && reset_out_n_oe
		|-> power_good_n_oe) else $error("linked reset without power-good");
	masked_count_a: assert property (!other_fault && !reset_out_n_oe ##1 !reset_out_n_oe
		|-> $stable(fault_error_count)) else $error("count moved without reset");
	count_init_a: assert property ($fell(low_power_mode) |-> fault_error_count == CNT_INIT)
		else $error("count not back to one");
	count_cap_a: assert property (init_done |-> fault_error_count <= lim)
		else $error("count above its limit");
	drive_low_a: assert property (!power_good_n_o && !reset_out_n_o)
		else $error("open-drain data not low");
endmodule : failsafe_reset_output_ctrl_checker
bind failsafe_reset_output_ctrl failsafe_reset_output_ctrl_checker #(
	.STUCK_LOW_CYCLES(STUCK_LOW_CYCLES), .RELEASE_CYCLES(RELEASE_CYCLES)) chk_i (
	.core_clk(core_clk), .rst_n(rst_n), .low_power_mode(low_power_mode),
	.init_done(init_done), .cfg_in(cfg_in), .mon_fault(mon_fault), .other_fault(other_fault),
	.power_good_n_oe(power_good_n_oe), .power_good_n_o(power_good_n_o),
	.reset_out_n_oe(reset_out_n_oe), .reset_out_n_o(reset_out_n_o),
	.reset_out_n_i(reset_out_n_i), .stuck_high_flag(stuck_high_flag),
	.deep_failsafe_state(deep_failsafe_state), .fault_error_count(fault_error_count));

/* File: failsafe_reset_output_ctrl_test.sv */
/*
 * Self-checking bench: drives faults and modes, queues expected outputs.
 * Assumes the far-side model resolves both open-drain lines.
 */
`timescale 1ns/100ps
module failsafe_reset_output_ctrl_test;
	import fsro_pkg::*;
	localparam logic [3:0] LIM [4] = '{CNT_MAX_00, CNT_MAX_01, CNT_MAX_10, CNT_MAX_11};
	logic       core_clk = 1'b0;
	logic       rst_n, low_power_mode, init_done, other_fault, hold_low, short_high;
	logic       pg_oe, rst_oe, pg_i, rst_i, stuck, deep, diag;
	logic [3:0] cnt;
	logic [8:0] obs;
	logic [17:0] e;
	logic [17:0] q [$];
	fs_cfg_t    c, cfg_in;
	mon_fault_t mon_fault;
	int         n_errors = 0;
	int         checks = 0;
	event       smp;
	assign obs = {pg_oe, rst_oe, deep, stuck, diag, cnt};
	// Clock
	always #5 core_clk = !core_clk;
	fsro_mcu_model mcu (.pg_oe(pg_oe), .rst_oe(rst_oe), .hold_low(hold_low),
		.short_high(short_high), .pg_pin(pg_i), .rst_pin(rst_i));
	failsafe_reset_output_ctrl #(.STUCK_LOW_CYCLES(200), .RELEASE_CYCLES(20)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .low_power_mode(low_power_mode),
		.init_done(init_done), .cfg_in(cfg_in), .mon_fault(mon_fault), .pulse_req(1'b0),
		.other_fault(other_fault), .power_good_n_oe(pg_oe), .power_good_n_o(),
		.power_good_n_i(pg_i), .reset_out_n_oe(rst_oe), .reset_out_n_o(),
		.reset_out_n_i(rst_i), .stuck_high_flag(stuck), .deep_failsafe_state(deep),
		.fault_error_count(cnt), .fault_diag_flag(diag));
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t outputs %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic ex(input logic [8:0] m, input logic [8:0] v);
		q.push_back({m, v});
		->smp;
	endtask : ex
	task automatic w(input int n);
		repeat (n) @(negedge core_clk);
	endtask : w
	task automatic st(input fs_cfg_t k);
		rst_n = 1'b0;
		{low_power_mode, init_done, other_fault, hold_low, short_high} = 5'h00;
		mon_fault = '0;
		cfg_in = k;
		w(20);
		ex(9'h1FF, 9'h181);
		rst_n = 1'b1;
		w(10);
		ex(9'h180, 9'h080);
		w(15);
		ex(9'h180, 9'h000);
		init_done = 1'b1;
		w(2);
	endtask : st
	task automatic stop_test;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// Compare each queued note with the outputs
	always begin
		@(smp);
		while (q.size() > 0) begin
			e = q.pop_front();
			chk(obs & e[17:9], e[8:0] & e[17:9]);
		end
	end
	// Watchdog
	initial begin
		#1000000;
		n_errors++;
		stop_test;
	end
	// Main sequence
	initial begin
		void'($urandom(27386));
		for (int m = 0; m < 3; m++) begin
			c = '0;
			c.fault_count_max_sel = 2'h3;
			c.reset_pulse_length_sel = 1'($urandom);
			c.pg_assign = 3'h1 << m;
			st(c);
			mon_fault.uv[(m + 1) % 3] = 1'b1;
			w(2);
			ex(9'h1FF, 9'h011);
			if ($urandom % 2) mon_fault.ov[m] = 1'b1;
			else mon_fault.uv[m] = 1'b1;
			w(2);
			ex(9'h1C0, 9'h180);
		end
		for (int l = 0; l < 2; l++) begin
			c = '0;
			c.fault_count_max_sel = 2'h3;
			c.uv_rst_en = 3'h1;
			c.pg_reset_link_cfg = l[0];
			st(c);
			mon_fault.uv[0] = 1'b1;
			w(2);
			ex(9'h18F, l ? 9'h182 : 9'h082);
		end
		short_high = 1'b1;
		w(49000);
		ex(9'h020, 9'h000);
		w(1100);
		ex(9'h020, 9'h020);
		for (int s = 0; s < 4; s++) begin
			c = '0;
			c.fault_count_max_sel = s[1:0];
			st(c);
			repeat (LIM[s] - 4'h1) begin
				other_fault = 1'b1;
				w(1);
				other_fault = 1'b0;
				w(1);
			end
			ex(9'h04F, {5'h00, LIM[s]});
			if (s == 0) begin
				low_power_mode = 1'b1;
				w(2);
				ex(9'h18F, 9'h181);
			end else begin
				other_fault = 1'b1;
				w(1);
				other_fault = 1'b0;
				w(2);
				ex(9'h1C0, 9'h1C0);
			end
		end
		st('0);
		hold_low = 1'b1;
		w(150);
		ex(9'h040, 9'h000);
		w(100);
		ex(9'h1C0, 9'h1C0);
		w(1);
		stop_test;
	end
endmodule : failsafe_reset_output_ctrl_test
